// >>> common/gfs_consts.vh
/*
  Constants of the general-purpose pin function-select block: register
  indices, reset values and function codes.
  Assumes it is included by bare name from the core files.
*/
`ifndef GFS_CONSTS_VH
`define GFS_CONSTS_VH

// register indices; the byte address on the bus is the index times four
`define GFS_IDX_W 10
`define GFS_IDX_DIR 10'h030
`define GFS_IDX_ISEL_HI 10'h031
`define GFS_IDX_ISEL_MID 10'h032
`define GFS_IDX_ISEL_LO 10'h033
`define GFS_IDX_OUTPUT_ENABLE_SELECTOR_HI 10'h034
`define GFS_IDX_OUTPUT_ENABLE_SELECTOR_MID 10'h035
`define GFS_IDX_OUTPUT_ENABLE_SELECTOR_LO 10'h036
`define GFS_IDX_SW_OUT 10'h037
`define GFS_IDX_SAMP_IN 10'h20C

// reset values, one bit per pin in each sliced register
`define GFS_DIR_RST 4'h0
`define GFS_ISEL_HI_RST 4'h0
`define GFS_ISEL_MID_RST 4'h0
`define GFS_ISEL_LO_RST 4'hF
`define GFS_OUTPUT_ENABLE_SELECTOR_RST 4'h0
`define GFS_SW_OUT_RST 4'h0
`define GFS_SAMP_RST 4'h0

// function codes
`define GFS_FN_GP 3'h0
`define GFS_FN_ALT 3'h1

// direction bit values
`define GFS_DIR_IN 1'b0
`define GFS_DIR_OUT 1'b1

// zero padding above the four pin bits on read
`define GFS_RD_PAD 28'h000_0000
`define GFS_RD_ZERO 32'h0000_0000

`endif

// >>> core/gfs_sync.v
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes each bit is independent; no bus coherence is promised.
*/
`timescale 1ns/100ps
`default_nettype none

module gfs_sync #(
  parameter W = 4
) (
  input wire ref_clk,
  input wire nrst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] stable_reg;

  // the first stage feeds the second stage only
  always @(posedge ref_clk) begin
    if (!nrst) begin
      meta_reg <= {W{1'b0}};
      stable_reg <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule // gfs_sync

`default_nettype wire

// >>> core/gfs_pin_mux.v
/*
  Output-mode function mux for one general-purpose pin.
  Assumes fn comes from the output-function registers and flag is an
  internal status level on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gfs_consts.vh"

module gfs_pin_mux #(
  parameter HAS_ALT = 1
) (
  input wire dir,
  input wire [2:0] fn,
  input wire sw_value,
  input wire flag,
  output reg pin_next
);

  // reserved codes drive low so the pin never shows stale data
  always @* begin
    pin_next = 1'b0;
    if (dir == `GFS_DIR_OUT) begin
      case (fn)
        `GFS_FN_GP: pin_next = sw_value;
        `GFS_FN_ALT: pin_next = (HAS_ALT != 0) ? flag : 1'b0;
        default: pin_next = 1'b0;
      endcase
    end
  end

endmodule // gfs_pin_mux

`default_nettype wire

// >>> core/gfs_top.v
/*
  Function-select and output-value logic for four general-purpose pins,
  with an APB register slave. Pin inputs pass a two-flop synchroniser;
  status flags come from logic on ref_clk. One clock, synchronous reset.
*/
// How it works
// - pin 0 input code 000: pin to input bit 0
// - pin 0 input code 001 (reset): output-enable select bit 0
// - pin 3 output code 000 drives software bit 3
// - pin 2 output code 000 drives software bit 2
// - pin 2 code resets 000; 001 shows ref0 loss
// - pin 1 output code 000 drives software bit 1
// - pin 1 output code 001 shows ref1 loss
// - pin 0 output code 000 drives software bit 0
// - pin 0 output code 001 shows holdover flag
// - software output values read/write, reset zero
// - direction bit: 0 input, 1 output, reset input
// - sampled input levels readable in read-only register
`timescale 1ns/100ps
`default_nettype none
`include "gfs_consts.vh"

module gfs_top #(
  parameter NPIN = 4,
  parameter AW = 12
) (
  input wire ref_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NPIN-1:0] gpio_in,
  output wire [NPIN-1:0] gpio_out,
  output wire [NPIN-1:0] gpio_oe,
  input wire ref0_loss_of_signal,
  input wire ref1_loss_of_signal,
  input wire dpll_holdover,
  output wire [1:0] output_enable_selector,
  output wire manual_clock_select
);

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------

  // word-aligned match of a register index against the bus address
  function hit;
    input [AW-1:0] addr;
    input [`GFS_IDX_W-1:0] idx;
    begin
      hit = (addr == {idx, 2'b00});
    end
  endfunction

  // read-only registers refuse writes with an error
  function is_rw;
    input [AW-1:0] addr;
    begin
      is_rw = hit(addr, `GFS_IDX_DIR) | hit(addr, `GFS_IDX_ISEL_HI) |
              hit(addr, `GFS_IDX_ISEL_MID) | hit(addr, `GFS_IDX_ISEL_LO) |
              hit(addr, `GFS_IDX_OUTPUT_ENABLE_SELECTOR_HI) | hit(addr, `GFS_IDX_OUTPUT_ENABLE_SELECTOR_MID) |
              hit(addr, `GFS_IDX_OUTPUT_ENABLE_SELECTOR_LO) | hit(addr, `GFS_IDX_SW_OUT);
    end
  endfunction

  // --------------------------------------------------------------------
  // function decode
  // --------------------------------------------------------------------

  // three-bit function code of pin k, gathered from the sliced registers
  function [2:0] code_of;
    input [NPIN-1:0] hi;
    input [NPIN-1:0] mid;
    input [NPIN-1:0] lo;
    input integer k;
    begin
      code_of = {hi[k], mid[k], lo[k]};
    end
  endfunction

  // pin k is in input mode with the wanted input code; every register is
  // an argument so that a combinational caller sees all of them change
  function in_is;
    input [NPIN-1:0] dir;
    input [NPIN-1:0] hi;
    input [NPIN-1:0] mid;
    input [NPIN-1:0] lo;
    input integer k;
    input [2:0] want;
    begin
      in_is = (dir[k] == `GFS_DIR_IN) && (code_of(hi, mid, lo, k) == want);
    end
  endfunction

  // --------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------

  reg [NPIN-1:0] dir_reg;
  reg [NPIN-1:0] isel_hi_reg;
  reg [NPIN-1:0] isel_mid_reg;
  reg [NPIN-1:0] isel_lo_reg;
  reg [NPIN-1:0] output_enable_selector_hi_reg;
  reg [NPIN-1:0] output_enable_selector_mid_reg;
  reg [NPIN-1:0] output_enable_selector_lo_reg;
  reg [NPIN-1:0] software_output_values_reg;
  reg [NPIN-1:0] sampled_input_values_reg;
  wire [NPIN-1:0] sampled_input_values_next;
  reg [NPIN-1:0] gpio_out_reg;
  wire [NPIN-1:0] gpio_out_next;
  reg [1:0] oe_sel_reg;
  reg [1:0] oe_sel_next;
  reg clk_sel_reg;
  reg clk_sel_next;
  reg [31:0] prdata_reg;
  reg [31:0] prdata_next;
  reg pslverr_reg;
  reg pslverr_next;

  wire setup_phase;
  wire wr_access;
  wire wr_ok;
  wire [NPIN-1:0] wdata;
  wire [NPIN-1:0] pin_level;
  wire [NPIN-1:0] flag_vec;

  // --------------------------------------------------------------------
  // APB handshake
  // --------------------------------------------------------------------

  // zero-wait slave: answer data and error are prepared in the setup
  // cycle so that in the access cycle prdata comes straight from a flip-flop and pslverr from a flip-flop gated by pready
  assign setup_phase = psel & ~penable;
  assign pready = psel & penable;
  assign wr_access = psel & penable & pwrite;
  assign wr_ok = wr_access & is_rw(paddr);
  // reserved upper bits are dropped on write
  assign wdata = pwdata[NPIN-1:0];

  always @* begin
    pslverr_next = pslverr_reg;
    if (setup_phase) begin
      pslverr_next = pwrite ? ~is_rw(paddr) : 1'b1;
      if (!pwrite && (is_rw(paddr) || hit(paddr, `GFS_IDX_SAMP_IN))) begin
        pslverr_next = 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------

  // reserved bits read as zero
  always @* begin
    prdata_next = prdata_reg;
    if (setup_phase) begin
      prdata_next = `GFS_RD_ZERO;
      if (!pwrite) begin
        if (hit(paddr, `GFS_IDX_DIR)) begin
          prdata_next = {`GFS_RD_PAD, dir_reg};
        end else if (hit(paddr, `GFS_IDX_ISEL_HI)) begin
          prdata_next = {`GFS_RD_PAD, isel_hi_reg};
        end else if (hit(paddr, `GFS_IDX_ISEL_MID)) begin
          prdata_next = {`GFS_RD_PAD, isel_mid_reg};
        end else if (hit(paddr, `GFS_IDX_ISEL_LO)) begin
          prdata_next = {`GFS_RD_PAD, isel_lo_reg};
        end else if (hit(paddr, `GFS_IDX_OUTPUT_ENABLE_SELECTOR_HI)) begin
          prdata_next = {`GFS_RD_PAD, output_enable_selector_hi_reg};
        end else if (hit(paddr, `GFS_IDX_OUTPUT_ENABLE_SELECTOR_MID)) begin
          prdata_next = {`GFS_RD_PAD, output_enable_selector_mid_reg};
        end else if (hit(paddr, `GFS_IDX_OUTPUT_ENABLE_SELECTOR_LO)) begin
          prdata_next = {`GFS_RD_PAD, output_enable_selector_lo_reg};
        end else if (hit(paddr, `GFS_IDX_SW_OUT)) begin
          prdata_next = {`GFS_RD_PAD, software_output_values_reg};
        end else if (hit(paddr, `GFS_IDX_SAMP_IN)) begin
          prdata_next = {`GFS_RD_PAD, sampled_input_values_reg};
        end
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      prdata_reg <= `GFS_RD_ZERO;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pready & pslverr_reg;

  // --------------------------------------------------------------------
  // writable registers
  // --------------------------------------------------------------------

  // reserved codes are stored as written; the pin logic treats them as
  // idle, since their effect is left to software not to use them
  always @(posedge ref_clk) begin
    if (!nrst) begin
      dir_reg <= `GFS_DIR_RST;
      isel_hi_reg <= `GFS_ISEL_HI_RST;
      isel_mid_reg <= `GFS_ISEL_MID_RST;
      isel_lo_reg <= `GFS_ISEL_LO_RST;
      output_enable_selector_hi_reg <= `GFS_OUTPUT_ENABLE_SELECTOR_RST;
      output_enable_selector_mid_reg <= `GFS_OUTPUT_ENABLE_SELECTOR_RST;
      output_enable_selector_lo_reg <= `GFS_OUTPUT_ENABLE_SELECTOR_RST;
      software_output_values_reg <= `GFS_SW_OUT_RST;
    end else if (wr_ok) begin
      if (hit(paddr, `GFS_IDX_DIR)) begin
        dir_reg <= wdata;
      end
      if (hit(paddr, `GFS_IDX_ISEL_HI)) begin
        isel_hi_reg <= wdata;
      end
      if (hit(paddr, `GFS_IDX_ISEL_MID)) begin
        isel_mid_reg <= wdata;
      end
      if (hit(paddr, `GFS_IDX_ISEL_LO)) begin
        isel_lo_reg <= wdata;
      end
      if (hit(paddr, `GFS_IDX_OUTPUT_ENABLE_SELECTOR_HI)) begin
        output_enable_selector_hi_reg <= wdata;
      end
      if (hit(paddr, `GFS_IDX_OUTPUT_ENABLE_SELECTOR_MID)) begin
        output_enable_selector_mid_reg <= wdata;
      end
      if (hit(paddr, `GFS_IDX_OUTPUT_ENABLE_SELECTOR_LO)) begin
        output_enable_selector_lo_reg <= wdata;
      end
      if (hit(paddr, `GFS_IDX_SW_OUT)) begin
        software_output_values_reg <= wdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // pin input path
  // --------------------------------------------------------------------

  gfs_sync #(
    .W(NPIN)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in(gpio_in),
    .sync_out(pin_level)
  );

  // a pin in output mode or with another function reads back as zero,
  // so software never mistakes a driven or control pin for an input
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_in
      // reserved input codes leave the pin unused and reading zero
      assign sampled_input_values_next[gi] =
        in_is(dir_reg, isel_hi_reg, isel_mid_reg, isel_lo_reg, gi, `GFS_FN_GP) ?
        pin_level[gi] : 1'b0;
    end
  endgenerate

  // pin 0 and pin 1 at code 001 carry the output-enable select bits;
  // pin 2 at code 001 is the manual clock select
  // pin 3 has no control function, so its code 001 is ignored
  always @* begin
    oe_sel_next = 2'b00;
    clk_sel_next = 1'b0;
    if (in_is(dir_reg, isel_hi_reg, isel_mid_reg, isel_lo_reg, 0, `GFS_FN_ALT)) begin
      oe_sel_next[0] = pin_level[0];
    end
    if (in_is(dir_reg, isel_hi_reg, isel_mid_reg, isel_lo_reg, 1, `GFS_FN_ALT)) begin
      oe_sel_next[1] = pin_level[1];
    end
    if (in_is(dir_reg, isel_hi_reg, isel_mid_reg, isel_lo_reg, 2, `GFS_FN_ALT)) begin
      clk_sel_next = pin_level[2];
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      sampled_input_values_reg <= `GFS_SAMP_RST;
      oe_sel_reg <= 2'b00;
      clk_sel_reg <= 1'b0;
    end else begin
      sampled_input_values_reg <= sampled_input_values_next;
      oe_sel_reg <= oe_sel_next;
      clk_sel_reg <= clk_sel_next;
    end
  end

  assign output_enable_selector = oe_sel_reg;
  assign manual_clock_select = clk_sel_reg;

  // --------------------------------------------------------------------
  // pin output path
  // --------------------------------------------------------------------

  // pin 3 has no status function; pin 2 shows reference 0 loss,
  // pin 1 reference 1 loss, pin 0 the holdover flag
  assign flag_vec = {1'b0, ref0_loss_of_signal, ref1_loss_of_signal, dpll_holdover};

  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_out
      gfs_pin_mux #(
        .HAS_ALT(gi != NPIN - 1)
      ) u_mux (
        .dir(dir_reg[gi]),
        .fn(code_of(output_enable_selector_hi_reg, output_enable_selector_mid_reg, output_enable_selector_lo_reg, gi)),
        .sw_value(software_output_values_reg[gi]),
        .flag(flag_vec[gi]),
        .pin_next(gpio_out_next[gi])
      );
    end
  endgenerate

  // one register stage keeps the pin glitch free and still shows a
  // flag change at the next edge
  always @(posedge ref_clk) begin
    if (!nrst) begin
      gpio_out_reg <= `GFS_SW_OUT_RST;
    end else begin
      gpio_out_reg <= gpio_out_next;
    end
  end

  assign gpio_out = gpio_out_reg;
  assign gpio_oe = dir_reg;

endmodule // gfs_top

`default_nettype wire

// >>> verif/gfs_top_props.sv
/*
  Checker for gfs_top: register side effects and pin function selection.
  Assumes it sees only the top ports; a shadow of the registers is rebuilt from APB writes.
*/
`timescale 1ns/100ps
`default_nettype none
module gfs_top_props #(
  parameter NPIN = 4,
  parameter AW = 12
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NPIN-1:0] gpio_in,
  input wire logic [NPIN-1:0] gpio_out,
  input wire logic [NPIN-1:0] gpio_oe,
  input wire logic ref0_loss_of_signal,
  input wire logic ref1_loss_of_signal,
  input wire logic dpll_holdover,
  input wire logic [1:0] output_enable_selector,
  input wire logic manual_clock_select
);
  // ----------------------------------------
  // register shadow
  // ----------------------------------------
  logic [3:0] dir_reg, ohi_reg, omid_reg, olo_reg, sw_reg, exp_next;
  wire wr_ok = psel && penable && pwrite && !pslverr;
  wire [3:0] flag = {1'b0, ref0_loss_of_signal, ref1_loss_of_signal, dpll_holdover};
  always @(posedge ref_clk) begin
    if (!nrst) begin
      dir_reg <= 4'h0;
      ohi_reg <= 4'h0;
      omid_reg <= 4'h0;
      olo_reg <= 4'h0;
      sw_reg <= 4'h0;
    end else if (wr_ok) begin
      case (paddr)
        12'h0C0: dir_reg <= pwdata[3:0];
        12'h0D0: ohi_reg <= pwdata[3:0];
        12'h0D4: omid_reg <= pwdata[3:0];
        12'h0D8: olo_reg <= pwdata[3:0];
        12'h0DC: sw_reg <= pwdata[3:0];
        default: ;
      endcase
    end
  end
  // pin 3 has no flag of its own, so its code 001 drives low
  always @* begin
    for (int k = 0; k < 4; k++) begin
      case ({ohi_reg[k], omid_reg[k], olo_reg[k]})
        3'h0: exp_next[k] = sw_reg[k];
        3'h1: exp_next[k] = flag[k];
        default: exp_next[k] = 1'b0;
      endcase
      exp_next[k] = exp_next[k] & dir_reg[k];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_pin0; gpio_out[0] == $past(exp_next[0]); endproperty
  a_pin0: assert property (p_pin0) else $error("pin 0 drive wrong");
  property p_pin1; gpio_out[1] == $past(exp_next[1]); endproperty
  a_pin1: assert property (p_pin1) else $error("pin 1 drive wrong");
  property p_pin2; gpio_out[2] == $past(exp_next[2]); endproperty
  a_pin2: assert property (p_pin2) else $error("pin 2 drive wrong");
  property p_pin3; gpio_out[3] == $past(exp_next[3]); endproperty
  a_pin3: assert property (p_pin3) else $error("pin 3 drive wrong");
  property p_hide; (gpio_out & ~gpio_oe & ~$past(gpio_oe)) == 4'h0; endproperty
  a_hide: assert property (p_hide) else $error("input pin driven");
  property p_sel; gpio_oe[0] [*2] |-> !output_enable_selector[0]; endproperty
  a_sel: assert property (p_sel) else $error("selector set in output mode");
  property p_dir;
    (psel && penable && pwrite && paddr == 12'h0C0) |=> gpio_oe == $past(pwdata[3:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction write lost");
  property p_rd_sw;
    (psel && penable && !pwrite && paddr == 12'h0DC) |-> prdata == {28'h000_0000, sw_reg};
  endproperty
  a_rd_sw: assert property (p_rd_sw) else $error("output value read wrong");
  property p_ro; (psel && penable && pwrite && paddr == 12'h830) |-> pslverr; endproperty
  a_ro: assert property (p_ro) else $error("read-only write accepted");
  c_flag: cover property (gpio_oe[2] && $rose(gpio_out[2]));
  c_sel: cover property ($rose(output_enable_selector[0]));
  c_err: cover property (pslverr);
endmodule // gfs_top_props
bind gfs_top gfs_top_props #(.NPIN(NPIN), .AW(AW)) gfs_top_props_i (
  .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
  .ref0_loss_of_signal(ref0_loss_of_signal), .ref1_loss_of_signal(ref1_loss_of_signal),
  .dpll_holdover(dpll_holdover), .output_enable_selector(output_enable_selector),
  .manual_clock_select(manual_clock_select));
`default_nettype wire

// >>> verif/gfs_board.sv
/*
  Board-side model of the four general-purpose pins.
  Assumes the device drives a pin only while its enable is high.
*/
`timescale 1ns/100ps
`default_nettype none
module gfs_board (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] board_level,
  output logic [3:0] pin_level
);
  // the device wins where it drives; the board sets every other pin
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule // gfs_board
`default_nettype wire

// >>> verif/tb.sv
/*
  Self-checking bench for gfs_top with the board model on its pins.
  Assumes the APB answer is awaited by a bounded loop, never counted on.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] board = 4'h0;
  logic [2:0] flags = 3'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [3:0] gpio_in;
  wire [3:0] gpio_out;
  wire [3:0] gpio_oe;
  wire [1:0] oesel;
  wire csel;
  int failures = 0;
  int n_tests = 0;
  always #5 ref_clk = ~ref_clk;
  gfs_top #(.NPIN(4), .AW(12)) gfs_top_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .ref0_loss_of_signal(flags[2]), .ref1_loss_of_signal(flags[1]),
    .dpll_holdover(flags[0]), .output_enable_selector(oesel), .manual_clock_select(csel));
  gfs_board gfs_board_i (.pin_out(gpio_out), .pin_oe(gpio_oe), .board_level(board),
    .pin_level(gpio_in));
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    int n;
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= is_wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
        failures++;
        close_out;
      end
    end
  endtask
  // upper data bits always go out as zero
  task wr(input logic [11:0] a, input logic [3:0] d, input logic e);
    logic [31:0] q;
    logic err;
    begin
      apb(1'b1, a, {28'h000_0000, d}, q, err);
      `CHK(err, e)
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input logic e);
    logic [31:0] q;
    logic err;
    begin
      apb(1'b0, a, 32'h0000_0000, q, err);
      `CHK(err, e)
      `CHK(q, x)
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task s_reset;
    begin
      `CHK(gpio_oe, 4'h0)
      rd(12'h0C0, 32'h0000_0000, 1'b0);
      rd(12'h0CC, 32'h0000_000F, 1'b0);
      rd(12'h0D4, 32'h0000_0000, 1'b0);
      rd(12'h0D8, 32'h0000_0000, 1'b0);
      rd(12'h0DC, 32'h0000_0000, 1'b0);
    end
  endtask
  task s_swout;
    begin
      wr(12'h0DC, 4'hA, 1'b0);
      wr(12'h0C0, 4'hF, 1'b0);
      @(posedge ref_clk);
      #1;
      `CHK(gpio_oe, 4'hF)
      `CHK(gpio_out, 4'hA)
      wr(12'h0DC, 4'h5, 1'b0);
      @(posedge ref_clk);
      #1;
      `CHK(gpio_out, 4'h5)
      rd(12'h0DC, 32'h0000_0005, 1'b0);
    end
  endtask
  task s_flags;
    begin
      wr(12'h0D8, 4'h7, 1'b0);
      for (int i = 0; i < 8; i++) begin
        @(posedge ref_clk);
        flags <= i[2:0];
        @(posedge ref_clk);
        #1;
        `CHK(gpio_out, {1'b0, i[2:0]})
      end
      wr(12'h0D8, 4'h0, 1'b0);
    end
  endtask
  task s_input;
    begin
      wr(12'h0C0, 4'h0, 1'b0);
      wr(12'h0CC, 4'h0, 1'b0);
      @(posedge ref_clk);
      board <= 4'h9;
      repeat (4) @(posedge ref_clk);
      rd(12'h830, 32'h0000_0009, 1'b0);
      wr(12'h0CC, 4'h3, 1'b0);
      @(posedge ref_clk);
      board <= 4'hE;
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK(oesel, 2'h2)
      rd(12'h830, 32'h0000_000C, 1'b0);
      wr(12'h0CC, 4'h7, 1'b0);
      @(posedge ref_clk);
      board <= 4'hD;
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK(oesel, 2'h1)
      `CHK(csel, 1'b1)
      rd(12'h830, 32'h0000_0008, 1'b0);
    end
  endtask
  task s_refuse;
    begin
      wr(12'h830, 4'hF, 1'b1);
      rd(12'h0E0, 32'h0000_0000, 1'b1);
      wr(12'h0C0, 4'h5, 1'b0);
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      #1;
      `CHK(gpio_oe, 4'h0)
      `CHK(gpio_out, 4'h0)
      rd(12'h0C0, 32'h0000_0000, 1'b0);
      rd(12'h0DC, 32'h0000_0000, 1'b0);
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    s_reset;
    s_swout;
    s_flags;
    s_input;
    s_refuse;
    close_out;
  end
  // a hang anywhere ends the run as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    close_out;
  end
endmodule // tb
`default_nettype wire
